//--- verilog/tmrc_timer.sv
`timescale 1ns/10ps
`default_nettype none
module tmrc_timer
  import tmrc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        osc_pin_a,
  input  wire logic        ovf_irq_ack,
  input  wire logic        match_irq_ack,
  output logic             ovf_irq,
  output logic             match_irq,
  output logic             compare_output
);
  logic       aph_ff;
  logic       wr_ff;
  logic [7:0] adr_ff;
  logic [7:0] ctrl_a_ff;
  logic [7:0] count_value_ff;
  logic [7:0] compare_value_ff;
  logic [7:0] cmp_buf_ff;
  logic [1:0] flag_ff;
  logic [1:0] irq_mask_ff;
  logic       async_ff;
  logic       block_ff;
  logic       match_ff;
  logic       compare_output_ff;
  tmrc_dir_t  dir_ff;
  logic [7:0] nxt_count;
  logic [7:0] nxt_compare;
  logic [7:0] nxt_buf;
  logic [1:0] nxt_flag;
  tmrc_dir_t  nxt_dir;
  logic       nxt_oc;
  logic [7:0] wdat;
  logic       timer_tick;
  logic [2:0] clock_select_field;
  logic [1:0] wave_mode_field;
  logic [1:0] output_action_field;
  logic       is_pwm;
  logic       wr_ctrl;
  logic       wr_cnt;
  logic       wr_cmp;
  logic       wr_flag;
  logic       wr_mask;
  logic       wr_async;
  logic       force_match_strobe;
  logic       at_top;
  logic       at_bottom;
  logic       at_max;
  logic       eq;
  logic       hit;
  logic       ovf_set;
  logic [7:0] top_val;
  logic [7:0] rd_mux;
  logic       mapped;

  assign clock_select_field  = ctrl_a_ff[TMRC_CS_LSB +: 3];
  assign wave_mode_field     = ctrl_a_ff[TMRC_WGM_LSB +: 2];
  assign output_action_field = ctrl_a_ff[TMRC_COM_LSB +: 2];
  assign is_pwm = wave_mode_field == TMRC_WGM_PCPWM ||
                  wave_mode_field == TMRC_WGM_FAST;

  tmrc_tick_gen u_tick (
    .ref_clk            (ref_clk),
    .rstn               (rstn),
    .clock_select_field (clock_select_field),
    .async_clock_select (async_ff),
    .osc_pin_a          (osc_pin_a),
    .timer_tick         (timer_tick)
  );

  // ahb-lite slave, zero wait states
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aph_ff <= 1'b0;
      wr_ff  <= 1'b0;
      adr_ff <= 8'h00;
    end
    else if (hready)
    begin
      aph_ff <= hsel && htrans[1];
      wr_ff  <= hwrite;
      adr_ff <= haddr[7:0];
    end
  end

  assign wdat     = hwdata[7:0];
  assign wr_ctrl  = aph_ff && wr_ff && adr_ff == TMRC_OFS_CTRL_A;
  assign wr_cnt   = aph_ff && wr_ff && adr_ff == TMRC_OFS_COUNT;
  assign wr_cmp   = aph_ff && wr_ff && adr_ff == TMRC_OFS_COMPARE;
  assign wr_flag  = aph_ff && wr_ff && adr_ff == TMRC_OFS_FLAG;
  assign wr_mask  = aph_ff && wr_ff && adr_ff == TMRC_OFS_MASK;
  assign wr_async = aph_ff && wr_ff && adr_ff == TMRC_OFS_ASYNC;
  assign force_match_strobe = aph_ff && wr_ff && adr_ff == TMRC_OFS_FORCE &&
                              wdat[TMRC_FOC_BIT] && !is_pwm;
  assign mapped = adr_ff == TMRC_OFS_CTRL_A || adr_ff == TMRC_OFS_COUNT ||
                  adr_ff == TMRC_OFS_COMPARE || adr_ff == TMRC_OFS_FLAG ||
                  adr_ff == TMRC_OFS_MASK || adr_ff == TMRC_OFS_ASYNC;

  always_comb
  begin
    case (adr_ff)
      TMRC_OFS_CTRL_A:  rd_mux = ctrl_a_ff;
      TMRC_OFS_COUNT:   rd_mux = count_value_ff;
      TMRC_OFS_COMPARE: rd_mux = is_pwm ? cmp_buf_ff : compare_value_ff;
      TMRC_OFS_FLAG:    rd_mux = {6'h00, flag_ff};
      TMRC_OFS_MASK:    rd_mux = {6'h00, irq_mask_ff};
      TMRC_OFS_ASYNC:   rd_mux = {7'h00, async_ff};
      default:          rd_mux = 8'h00;
    endcase
  end
  assign hrdata = (aph_ff && !wr_ff && mapped) ? {24'h000000, rd_mux} : 32'h0;

  // counter sequence
  assign top_val   = (wave_mode_field == TMRC_WGM_CTC) ? compare_value_ff
                                                       : TMRC_MAX;
  assign at_max    = count_value_ff == TMRC_MAX;
  assign at_bottom = count_value_ff == TMRC_BOTTOM;
  assign at_top    = count_value_ff == top_val;
  assign eq        = count_value_ff == compare_value_ff;
  assign hit       = timer_tick && eq && !block_ff;

  always_comb
  begin
    nxt_count = count_value_ff;
    nxt_dir   = dir_ff;
    if (wr_cnt)
      nxt_count = wdat;
    else if (timer_tick)
    begin
      case (wave_mode_field)
        TMRC_WGM_CTC:
          nxt_count = hit ? TMRC_BOTTOM : count_value_ff + 8'h01;
        TMRC_WGM_PCPWM:
        begin
          if (dir_ff == TMRC_UP && at_max)
          begin
            nxt_dir   = TMRC_DOWN;
            nxt_count = count_value_ff - 8'h01;
          end
          else if (dir_ff == TMRC_DOWN && at_bottom)
          begin
            nxt_dir   = TMRC_UP;
            nxt_count = count_value_ff + 8'h01;
          end
          else if (dir_ff == TMRC_DOWN)
            nxt_count = count_value_ff - 8'h01;
          else
            nxt_count = count_value_ff + 8'h01;
        end
        default:
          nxt_count = count_value_ff + 8'h01;
      endcase
    end
  end

  // overflow: wrap through max, or bottom turn in phase correct
  assign ovf_set = timer_tick && !wr_cnt &&
                   ((wave_mode_field == TMRC_WGM_PCPWM) ?
                    (dir_ff == TMRC_DOWN && at_bottom) : at_max);

  // compare register and buffer
  always_comb
  begin
    nxt_buf     = cmp_buf_ff;
    nxt_compare = compare_value_ff;
    if (wr_cmp && is_pwm)
      nxt_buf = wdat;
    else if (wr_cmp)
    begin
      nxt_compare = wdat;
      nxt_buf     = wdat;
    end
    if (is_pwm && timer_tick &&
        ((wave_mode_field == TMRC_WGM_FAST && at_max) ||
         (wave_mode_field == TMRC_WGM_PCPWM && dir_ff == TMRC_UP && at_max)))
      nxt_compare = cmp_buf_ff;
  end

  // flags: set wins over clear
  always_comb
  begin
    nxt_flag = flag_ff;
    if (wr_flag)
      nxt_flag = flag_ff & ~wdat[1:0];
    if (ovf_irq_ack)
      nxt_flag[TMRC_OVF_BIT] = 1'b0;
    if (match_irq_ack)
      nxt_flag[TMRC_MAT_BIT] = 1'b0;
    if (ovf_set)
      nxt_flag[TMRC_OVF_BIT] = 1'b1;
    if (match_ff)
      nxt_flag[TMRC_MAT_BIT] = 1'b1;
  end

  // waveform output
  always_comb
  begin
    nxt_oc = compare_output_ff;
    case (wave_mode_field)
      TMRC_WGM_FAST:
      begin
        if (output_action_field == TMRC_COM_CLEAR)
        begin
          if (hit) nxt_oc = 1'b0;
          else if (timer_tick && at_max) nxt_oc = 1'b1;
        end
        else if (output_action_field == TMRC_COM_SET)
        begin
          if (hit) nxt_oc = 1'b1;
          else if (timer_tick && at_max) nxt_oc = 1'b0;
        end
      end
      TMRC_WGM_PCPWM:
      begin
        if (hit && output_action_field == TMRC_COM_CLEAR)
          nxt_oc = dir_ff == TMRC_DOWN;
        else if (hit && output_action_field == TMRC_COM_SET)
          nxt_oc = dir_ff == TMRC_UP;
      end
      default:
      begin
        if (hit || force_match_strobe)
        begin
          case (output_action_field)
            TMRC_COM_TOGGLE: nxt_oc = ~compare_output_ff;
            TMRC_COM_CLEAR:  nxt_oc = 1'b0;
            TMRC_COM_SET:    nxt_oc = 1'b1;
            default:         nxt_oc = compare_output_ff;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_a_ff         <= 8'h00;
      count_value_ff    <= TMRC_BOTTOM;
      compare_value_ff  <= 8'h00;
      cmp_buf_ff        <= 8'h00;
      flag_ff           <= 2'h0;
      irq_mask_ff       <= 2'h0;
      async_ff          <= 1'b0;
      block_ff          <= 1'b0;
      match_ff          <= 1'b0;
      compare_output_ff <= 1'b0;
      dir_ff            <= TMRC_UP;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_a_ff <= wdat;
      if (wr_mask)
        irq_mask_ff <= wdat[1:0];
      if (wr_async)
        async_ff <= wdat[TMRC_AS_BIT];
      count_value_ff    <= nxt_count;
      compare_value_ff  <= nxt_compare;
      cmp_buf_ff        <= nxt_buf;
      flag_ff           <= nxt_flag;
      dir_ff            <= nxt_dir;
      compare_output_ff <= nxt_oc;
      // write blocks match until next tick passes
      if (wr_cnt)
        block_ff <= 1'b1;
      else if (timer_tick)
        block_ff <= 1'b0;
      match_ff <= hit;
    end
  end

  assign ovf_irq   = flag_ff[TMRC_OVF_BIT] & irq_mask_ff[TMRC_OVF_BIT];
  assign match_irq = flag_ff[TMRC_MAT_BIT] & irq_mask_ff[TMRC_MAT_BIT];
  assign compare_output = compare_output_ff;

  a_match_flag_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    hit |=> match_ff ##1 flag_ff[TMRC_MAT_BIT])
    else $error("match flag not set after match");
  a_stop_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clock_select_field == TMRC_CS_STOP && !wr_cnt) |=>
      count_value_ff == $past(count_value_ff))
    else $error("counter moved while stopped");
  a_cpu_write_wins: assert property (@(posedge ref_clk) disable iff (!rstn)
    wr_cnt |=> count_value_ff == $past(wdat))
    else $error("cpu write lost");
  a_write_blocks: assert property (@(posedge ref_clk) disable iff (!rstn)
    (block_ff && timer_tick && !wr_cnt) |=>
      !match_ff && !block_ff)
    else $error("match not blocked");
  a_match_irq_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    (match_ff && irq_mask_ff[TMRC_MAT_BIT] && !wr_mask) |=>
      match_irq)
    else $error("match irq not raised");
  a_ctc_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
    (wave_mode_field == TMRC_WGM_CTC && hit && !wr_cnt) |=>
      count_value_ff == TMRC_BOTTOM)
    else $error("ctc did not clear");
  a_normal_ovf: assert property (@(posedge ref_clk) disable iff (!rstn)
    (wave_mode_field == TMRC_WGM_NORMAL && timer_tick && at_max && !wr_cnt)
      |=> count_value_ff == TMRC_BOTTOM && flag_ff[TMRC_OVF_BIT])
    else $error("normal wrap or overflow wrong");
  a_force_no_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    (force_match_strobe && !hit && !match_ff && !flag_ff[TMRC_MAT_BIT])
      |=> !flag_ff[TMRC_MAT_BIT])
    else $error("force set match flag");
  a_nopwm_direct: assert property (@(posedge ref_clk) disable iff (!rstn)
    (wr_cmp && !is_pwm) |=> compare_value_ff == $past(wdat))
    else $error("compare not written directly");
  a_com_zero_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
    (output_action_field == TMRC_COM_NONE && !wr_ctrl) |=>
      $stable(compare_output_ff))
    else $error("output changed with action zero");

  c_ctc_match: cover property (@(posedge ref_clk) disable iff (!rstn)
    wave_mode_field == TMRC_WGM_CTC && hit);
  c_fast_reload: cover property (@(posedge ref_clk) disable iff (!rstn)
    wave_mode_field == TMRC_WGM_FAST && timer_tick && at_max);
  c_force: cover property (@(posedge ref_clk) disable iff (!rstn)
    force_match_strobe);
  c_overflow: cover property (@(posedge ref_clk) disable iff (!rstn)
    ovf_set);
endmodule : tmrc_timer
`default_nettype wire

//--- verilog/tmrc_pkg.sv
package tmrc_pkg;
  localparam logic [7:0] TMRC_BOTTOM      = 8'h00;
  localparam logic [7:0] TMRC_MAX         = 8'hFF;
  localparam logic [7:0] TMRC_OFS_CTRL_A  = 8'h00;
  localparam logic [7:0] TMRC_OFS_COUNT   = 8'h04;
  localparam logic [7:0] TMRC_OFS_COMPARE = 8'h08;
  localparam logic [7:0] TMRC_OFS_FLAG    = 8'h0C;
  localparam logic [7:0] TMRC_OFS_MASK    = 8'h10;
  localparam logic [7:0] TMRC_OFS_ASYNC   = 8'h14;
  localparam logic [7:0] TMRC_OFS_FORCE   = 8'h18;
  localparam int TMRC_CS_LSB   = 0;
  localparam int TMRC_WGM_LSB  = 3;
  localparam int TMRC_COM_LSB  = 5;
  localparam int TMRC_OVF_BIT  = 0;
  localparam int TMRC_MAT_BIT  = 1;
  localparam int TMRC_FOC_BIT  = 0;
  localparam int TMRC_AS_BIT   = 0;
  localparam logic [1:0] TMRC_WGM_NORMAL = 2'h0;
  localparam logic [1:0] TMRC_WGM_PCPWM  = 2'h1;
  localparam logic [1:0] TMRC_WGM_CTC    = 2'h2;
  localparam logic [1:0] TMRC_WGM_FAST   = 2'h3;
  localparam logic [1:0] TMRC_COM_NONE   = 2'h0;
  localparam logic [1:0] TMRC_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TMRC_COM_CLEAR  = 2'h2;
  localparam logic [1:0] TMRC_COM_SET    = 2'h3;
  localparam logic [2:0] TMRC_CS_STOP    = 3'h0;
  localparam logic [1:0] TMRC_HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {
    TMRC_UP   = 2'b01,
    TMRC_DOWN = 2'b10
  } tmrc_dir_t;
endpackage : tmrc_pkg

//--- verilog/tmrc_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
// selects source and divides it into one-cycle timer ticks
module tmrc_tick_gen
  import tmrc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic [2:0] clock_select_field,
  input  wire logic       async_clock_select,
  input  wire logic       osc_pin_a,
  output logic            timer_tick
);
  logic       osc_s1_ff;
  logic       osc_s2_ff;
  logic       osc_s3_ff;
  logic [9:0] pre_ff;
  logic       src_tick;
  logic       sel_bit;
  logic       prev_ff;
  logic [9:0] nxt_pre;

  // oscillator edge, sync first stage read only by second
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      osc_s1_ff <= 1'b0;
      osc_s2_ff <= 1'b0;
      osc_s3_ff <= 1'b0;
    end
    else
    begin
      osc_s1_ff <= osc_pin_a;
      osc_s2_ff <= osc_s1_ff;
      osc_s3_ff <= osc_s2_ff;
    end
  end

  assign src_tick = async_clock_select ? (osc_s2_ff & ~osc_s3_ff) : 1'b1;
  assign nxt_pre  = src_tick ? pre_ff + 10'h001 : pre_ff;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      pre_ff <= 10'h000;
    else
      pre_ff <= nxt_pre;
  end

  always_comb
  begin
    case (clock_select_field)
      3'h2:    sel_bit = pre_ff[2];
      3'h3:    sel_bit = pre_ff[4];
      3'h4:    sel_bit = pre_ff[5];
      3'h5:    sel_bit = pre_ff[6];
      3'h6:    sel_bit = pre_ff[7];
      3'h7:    sel_bit = pre_ff[9];
      default: sel_bit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      prev_ff <= 1'b0;
    else
      prev_ff <= sel_bit;
  end

  // stopped when select is zero
  assign timer_tick = (clock_select_field == TMRC_CS_STOP) ? 1'b0 :
                      (clock_select_field == 3'h1) ? src_tick :
                      (sel_bit & ~prev_ff);
endmodule : tmrc_tick_gen
`default_nettype wire

//--- tb/tmrc_xtal_model.sv
`timescale 1ns/10ps
`default_nettype none
// slow crystal seen at the oscillator pin, idle low between bursts
module tmrc_xtal_model
(
  input  wire logic ref_clk,
  output var logic  osc_pin_a
);
  initial osc_pin_a = 1'b0;

  // n rising edges, then quiet long enough for sync and count update
  task automatic emit(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      osc_pin_a <= 1'b1;
      repeat (4) @(posedge ref_clk);
      osc_pin_a <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    repeat (8) @(posedge ref_clk);
  endtask : emit
endmodule : tmrc_xtal_model
`default_nettype wire

//--- tb/eight_bit_async_timer_compare_test.sv
`timescale 1ns/10ps
`default_nettype none
module eight_bit_async_timer_compare_test
  import tmrc_pkg::*;
;
  logic        ref_clk;
  logic        rstn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        osc_pin_a;
  logic        ovf_irq_ack;
  logic        match_irq_ack;
  logic        ovf_irq;
  logic        match_irq;
  logic        compare_output;
  int          bad_count;
  int          n_compared;

  // output selectors for pin checks
  localparam logic [1:0] PIN_OC  = 2'h0;
  localparam logic [1:0] PIN_OVF = 2'h1;
  localparam logic [1:0] PIN_MAT = 2'h2;

  tmrc_timer uut
  (
    .ref_clk        (ref_clk),
    .rstn           (rstn),
    .hsel           (hsel),
    .haddr          (haddr),
    .htrans         (htrans),
    .hwrite         (hwrite),
    .hsize          (hsize),
    .hwdata         (hwdata),
    .hready         (hreadyout),
    .hrdata         (hrdata),
    .hreadyout      (hreadyout),
    .hresp          (hresp),
    .osc_pin_a      (osc_pin_a),
    .ovf_irq_ack    (ovf_irq_ack),
    .match_irq_ack  (match_irq_ack),
    .ovf_irq        (ovf_irq),
    .match_irq      (match_irq),
    .compare_output (compare_output)
  );

  tmrc_xtal_model xtal
  (
    .ref_clk   (ref_clk),
    .osc_pin_a (osc_pin_a)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_compared++;
    if (got !== exp)
    begin
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      bad_count++;
    end
  endtask : chk

  // bounded wait for hready high at a rising edge
  task automatic wait_rdy;
    int k;
    k = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1)
    begin
      k++;
      if (k > 50)
      begin
        $display("[ERR] %0t bus hang", $time);
        bad_count++;
        close_out();
      end
      @(posedge ref_clk);
    end
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= TMRC_HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wr ? d : 32'h0;
    wait_rdy();
    q = hrdata;
    chk({31'h0, hresp}, 32'h0, "hresp okay");
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e, m);
  endtask : rd

  // sample the chosen output two edges after the last write settled
  task automatic pin(input logic [1:0] s, input logic e, input string m);
    logic g;
    repeat (2) @(posedge ref_clk);
    g = (s == PIN_OC) ? compare_output :
        (s == PIN_OVF) ? ovf_irq : match_irq;
    chk({31'h0, g}, {31'h0, e}, m);
  endtask : pin

  task automatic ack(input logic which);
    @(posedge ref_clk);
    if (which)
      match_irq_ack <= 1'b1;
    else
      ovf_irq_ack <= 1'b1;
    @(posedge ref_clk);
    match_irq_ack <= 1'b0;
    ovf_irq_ack   <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : ack

  function automatic logic [31:0] ctl(input logic [2:0] cs,
                                      input logic [1:0] wgm,
                                      input logic [1:0] com);
    return {25'h0, com, wgm, cs};
  endfunction : ctl

  initial
  begin
    logic [7:0]  ofs [8];
    logic [1:0]  fcom [4];
    logic        fexp [4];
    ofs  = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h40};
    fcom = '{TMRC_COM_CLEAR, TMRC_COM_SET, TMRC_COM_TOGGLE, TMRC_COM_NONE};
    fexp = '{1'b0, 1'b1, 1'b0, 1'b0};
    bad_count = 0;
    n_compared = 0;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ovf_irq_ack = 1'b0;
    match_irq_ack = 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], 32'h0, "reset value");
    pin(PIN_OC, 1'b0, "reset output");
    $display("test reset done");
    wr(TMRC_OFS_COUNT, 32'h1AB);
    rd(TMRC_OFS_COUNT, 32'hAB, "count width");
    wr(TMRC_OFS_ASYNC, 32'h1);
    xtal.emit(4);
    rd(TMRC_OFS_COUNT, 32'hAB, "stopped count");
    $display("test stopped done");
    wr(TMRC_OFS_COMPARE, 32'h40);
    wr(TMRC_OFS_COUNT, 32'hFD);
    wr(TMRC_OFS_CTRL_A, ctl(3'h1, TMRC_WGM_NORMAL, TMRC_COM_NONE));
    xtal.emit(3);
    rd(TMRC_OFS_COUNT, 32'h00, "wrap");
    rd(TMRC_OFS_FLAG, 32'h1, "overflow flag");
    pin(PIN_OVF, 1'b0, "masked ovf");
    wr(TMRC_OFS_MASK, 32'h1);
    pin(PIN_OVF, 1'b1, "ovf irq");
    ack(1'b0);
    rd(TMRC_OFS_FLAG, 32'h0, "ovf ack");
    $display("test normal done");
    wr(TMRC_OFS_COUNT, 32'h01);
    wr(TMRC_OFS_COMPARE, 32'h03);
    wr(TMRC_OFS_CTRL_A, ctl(3'h1, TMRC_WGM_NORMAL, TMRC_COM_TOGGLE));
    xtal.emit(2);
    rd(TMRC_OFS_FLAG, 32'h0, "early match");
    xtal.emit(1);
    rd(TMRC_OFS_FLAG, 32'h2, "match flag");
    pin(PIN_OC, 1'b1, "toggle");
    pin(PIN_MAT, 1'b0, "masked match");
    wr(TMRC_OFS_MASK, 32'h3);
    pin(PIN_MAT, 1'b1, "match irq");
    wr(TMRC_OFS_FLAG, 32'h2);
    rd(TMRC_OFS_FLAG, 32'h0, "write one clear");
    $display("test match done");
    wr(TMRC_OFS_COUNT, 32'h00);
    wr(TMRC_OFS_CTRL_A, ctl(3'h1, TMRC_WGM_CTC, TMRC_COM_NONE));
    xtal.emit(4);
    rd(TMRC_OFS_COUNT, 32'h00, "ctc clear");
    rd(TMRC_OFS_FLAG, 32'h2, "ctc flags");
    pin(PIN_OC, 1'b1, "action none");
    ack(1'b1);
    rd(TMRC_OFS_FLAG, 32'h0, "match ack");
    $display("test ctc done");
    wr(TMRC_OFS_CTRL_A, ctl(3'h1, TMRC_WGM_NORMAL, TMRC_COM_TOGGLE));
    wr(TMRC_OFS_COUNT, 32'h03);
    xtal.emit(1);
    rd(TMRC_OFS_COUNT, 32'h04, "count after block");
    rd(TMRC_OFS_FLAG, 32'h0, "blocked match");
    pin(PIN_OC, 1'b1, "blocked output");
    $display("test block done");
    foreach (fcom[i])
    begin
      wr(TMRC_OFS_CTRL_A, ctl(3'h1, TMRC_WGM_NORMAL, fcom[i]));
      wr(TMRC_OFS_FORCE, 32'h1);
      pin(PIN_OC, fexp[i], "forced output");
    end
    rd(TMRC_OFS_FLAG, 32'h0, "force no flag");
    rd(TMRC_OFS_COUNT, 32'h04, "force no clear");
    rd(TMRC_OFS_FORCE, 32'h0, "force reads zero");
    $display("test force done");
    wr(TMRC_OFS_CTRL_A, ctl(3'h1, TMRC_WGM_FAST, TMRC_COM_NONE));
    wr(TMRC_OFS_COMPARE, 32'h30);
    wr(TMRC_OFS_COUNT, 32'h01);
    xtal.emit(3);
    rd(TMRC_OFS_FLAG, 32'h2, "old compare active");
    wr(TMRC_OFS_FLAG, 32'h3);
    wr(TMRC_OFS_CTRL_A, ctl(3'h1, TMRC_WGM_FAST, TMRC_COM_CLEAR));
    wr(TMRC_OFS_COUNT, 32'hFE);
    xtal.emit(2);
    rd(TMRC_OFS_FLAG, 32'h1, "fast overflow");
    pin(PIN_OC, 1'b1, "set at bottom");
    wr(TMRC_OFS_FLAG, 32'h3);
    wr(TMRC_OFS_COUNT, 32'h2F);
    xtal.emit(2);
    rd(TMRC_OFS_FLAG, 32'h2, "new compare loaded");
    pin(PIN_OC, 1'b0, "clear on match");
    wr(TMRC_OFS_CTRL_A, ctl(3'h1, TMRC_WGM_FAST, TMRC_COM_SET));
    wr(TMRC_OFS_FORCE, 32'h1);
    pin(PIN_OC, 1'b0, "force ignored");
    $display("test pwm done");
    wr(TMRC_OFS_FLAG, 32'h3);
    wr(TMRC_OFS_CTRL_A, ctl(3'h1, TMRC_WGM_PCPWM, TMRC_COM_CLEAR));
    wr(TMRC_OFS_COUNT, 32'hFE);
    xtal.emit(3);
    rd(TMRC_OFS_COUNT, 32'hFD, "down count");
    rd(TMRC_OFS_FLAG, 32'h0, "no ovf at top");
    wr(TMRC_OFS_COUNT, 32'h02);
    xtal.emit(3);
    rd(TMRC_OFS_COUNT, 32'h01, "up after bottom");
    rd(TMRC_OFS_FLAG, 32'h1, "ovf at bottom");
    $display("test phase correct done");
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(TMRC_OFS_COUNT, 32'h0, "count after reset");
    rd(TMRC_OFS_FLAG, 32'h0, "flags after reset");
    rd(TMRC_OFS_MASK, 32'h0, "mask after reset");
    rd(TMRC_OFS_ASYNC, 32'h0, "async after reset");
    rd(TMRC_OFS_COMPARE, 32'h0, "compare after reset");
    $display("test second reset done");
    wr(TMRC_OFS_COUNT, 32'h00);
    wr(TMRC_OFS_CTRL_A, ctl(3'h1, TMRC_WGM_NORMAL, TMRC_COM_NONE));
    wr(TMRC_OFS_CTRL_A, 32'h0);
    rd(TMRC_OFS_COUNT, 32'h03, "io clock ticks");
    $display("test io clock done");
    close_out();
  end

  initial
  begin
    #640000;
    $display("[ERR] %0t run timeout", $time);
    bad_count++;
    close_out();
  end
endmodule : eight_bit_async_timer_compare_test
`default_nettype wire
